// file: dv/tb_top.sv
// self-checking bench for the modulus counter submodule
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
	$display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb_top;
	import mcs_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	mcs_req_type req = '0;
	logic count_pulse = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic irq;
	int fails = 0;
	int n_checks = 0;
	int seed = 32'h54e7;
	int cnt = 0;
	int lat = 0;
	int flag = 0;
	mcs_counter DUT (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
		.count_pulse(count_pulse), .rdata(rdata), .irq(irq));
	always #50 clk_sys = ~clk_sys;
	task automatic wr(input logic [ADDR_W-1:0] a, input int d);
		@(posedge clk_sys);
		req <= '{addr: a, wdata: d[15:0], wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		req.wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe is taken
	task automatic rchk(input logic [ADDR_W-1:0] a, input int e);
		@(posedge clk_sys);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		req.rd <= 1'b0;
		#1 `CHK(rdata, e[15:0])
	endtask
	// one count pulse, long enough for the synchroniser, then the model
	task automatic pulse();
		repeat (3) @(posedge clk_sys) count_pulse <= 1'b1;
		repeat (3) @(posedge clk_sys) count_pulse <= 1'b0;
		if (cnt == 'hffff) begin
			cnt = lat;
			flag = 1;
		end else
			cnt++;
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clk_sys);
		fails++;
		final_report();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		rchk(OFF_LATCH, 0);
		rchk(OFF_STATUS, 0);
		lat = $random(seed) & 'hffff;
		wr(OFF_LATCH, lat);
		rchk(OFF_LATCH, lat);
		repeat (3) pulse();
		rchk(OFF_COUNT, cnt);
		rchk(OFF_COUNT, cnt);
		wr(OFF_COUNT, 'hfffe);
		cnt = 'hfffe;
		lat = 'hfffe;
		rchk(OFF_LATCH, lat);
		lat = $random(seed) & 'hfffd;
		wr(OFF_LATCH, lat);
		rchk(OFF_COUNT, cnt);
		repeat (2) pulse();
		rchk(OFF_COUNT, cnt);
		rchk(OFF_STATUS, flag);
		`CHK(irq, 1'b0)
		wr(OFF_ENABLE, 1);
		#1 `CHK(irq, 1'b1)
		rchk(OFF_ENABLE, 1);
		wr(OFF_COUNT, 'hffff);
		cnt = 'hffff;
		lat = 'hffff;
		for (int i = 0; i < 3; i++) begin
			wr(OFF_CLEAR, 1);
			flag = 0;
			pulse();
			rchk(OFF_STATUS, flag);
			rchk(OFF_COUNT, cnt);
		end
		lat = $random(seed) & 'h7fff;
		wr(OFF_LATCH, lat);
		repeat (3) pulse();
		rchk(OFF_COUNT, cnt);
		rchk(OFF_STATUS, flag);
		wr(OFF_CLEAR, 1);
		flag = 0;
		#1 `CHK(irq, 1'b0)
		rchk(OFF_STATUS, flag);
		rchk(4'hf, 0);
		final_report();
	end
endmodule // tb_top

// file: rtl/count_value.sv
// modulus counter submodule with register port and overflow interrupt
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
// Operation
// [R1] The 16-bit reload latch can be written and read back at any time.
// [R2] Writing the latch alone changes only the latch; the counter takes it at the next reload.
// [R3] Writing the counter loads both the counter and the latch at once.
// [R4] Reset clears the reload latch to zero.
// [R5] The counter is a 16-bit register stepped by an incrementer on count pulses.
// [R6] Reading the counter returns the count without changing it.
// [R7] Overflow reloads the counter from the latch; a software write is the only other load.
// [R8] Every overflow sets the overflow flag in the status register.
// [R9] With the latch at all ones every count pulse overflows and sets the flag; the code overflows only while the count is all ones too (R10).
// [R10] Overflow happens on a pulse while the count is all ones; otherwise a pulse adds one.
// [R11] The flag stays set until software clears it; further overflows keep it set.
module mcs_counter (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire mcs_pkg::mcs_req_type req,
	input wire logic count_pulse,
	output logic [mcs_pkg::DATA_W-1:0] rdata,
	output logic irq
);
	import mcs_pkg::*;

	// one register access of a given kind at a given offset
	function automatic logic hit_write(input mcs_req_type r,
		input logic [ADDR_W-1:0] off);
		return r.wr && (r.addr == off);
	endfunction

	function automatic logic hit_read(input mcs_req_type r,
		input logic [ADDR_W-1:0] off);
		return r.rd && (r.addr == off);
	endfunction

	logic [DATA_W-1:0] latch;
	logic [DATA_W-1:0] count;
	logic counter_overflow_flag;
	logic irq_enable;
	logic pulse_meta;
	logic pulse_sync;
	logic pulse_prev;
	logic pulse_edge;
	logic overflow;
	logic count_wr;
	logic latch_wr;
	logic flag_clr;
	logic enable_wr;

	// count pulse comes from the count_pulse input, resynchronised
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pulse_meta <= 1'b0;
			pulse_sync <= 1'b0;
			pulse_prev <= 1'b0;
		end else begin
			pulse_meta <= count_pulse;
			pulse_sync <= pulse_meta;
			pulse_prev <= pulse_sync;
		end
	end

	assign pulse_edge = pulse_sync & ~pulse_prev;
	assign count_wr = hit_write(req, OFF_COUNT);
	assign latch_wr = hit_write(req, OFF_LATCH);
	assign enable_wr = hit_write(req, OFF_ENABLE);
	assign flag_clr = hit_write(req, OFF_CLEAR) && req.wdata[FLAG_BIT];
	assign overflow = pulse_edge && (count == ALL_ONES) && !count_wr; // R10

	// reload latch
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			latch <= LATCH_RST; // R4
		end else if (count_wr || latch_wr) begin
			latch <= req.wdata; // R1 R2 R3
		end
	end

	// counter: software write beats a coincident count pulse
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			count <= COUNT_RST;
		end else if (count_wr) begin
			count <= req.wdata; // R3
		end else if (overflow) begin
			count <= latch; // R7 R9
		end else if (pulse_edge) begin
			count <= count + ONE; // R5 R10
		end
	end

	// sticky overflow flag, set wins over clear
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			counter_overflow_flag <= 1'b0;
		end else if (overflow) begin
			counter_overflow_flag <= 1'b1; // R8 R11
		end else if (flag_clr) begin
			counter_overflow_flag <= 1'b0; // R11
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			irq_enable <= 1'b0;
		end else if (enable_wr) begin
			irq_enable <= req.wdata[FLAG_BIT];
		end
	end

	assign irq = counter_overflow_flag & irq_enable;

	// read data, valid the cycle after the read strobe only
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdata <= ZERO;
		end else if (!req.rd) begin
			rdata <= ZERO;
		end else if (req.addr == OFF_LATCH) begin
			rdata <= latch; // R1
		end else if (req.addr == OFF_COUNT) begin
			rdata <= count; // R6
		end else if (req.addr == OFF_STATUS) begin
			rdata <= {{(DATA_W-1){1'b0}}, counter_overflow_flag};
		end else if (req.addr == OFF_ENABLE) begin
			rdata <= {{(DATA_W-1){1'b0}}, irq_enable};
		end else begin
			rdata <= ZERO;
		end
	end

	sequence s_wrap;
		overflow;
	endsequence

	sequence s_step;
		pulse_edge && !count_wr && (count != ALL_ONES);
	endsequence

	sequence s_quiet;
		!count_wr && !pulse_edge;
	endsequence

	sequence s_read(logic [ADDR_W-1:0] off);
		hit_read(req, off);
	endsequence

	// a pin edge walking through the synchroniser into the edge detector
	sequence s_arrive;
		pulse_meta && !pulse_sync && !pulse_prev ##1 pulse_sync;
	endsequence

	chk_latch_reset: assert property (@(posedge clk_sys) // R4
		!rst_n |=> latch == LATCH_RST)
		else $error("latch not cleared by reset");
	chk_latch_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
		req.wr && req.addr == OFF_LATCH |=> latch == $past(req.wdata))
		else $error("latch write lost");
	chk_latch_only: assert property (@(posedge clk_sys) disable iff (!rst_n) // R2
		latch_wr && !overflow && !pulse_edge |=> $stable(count))
		else $error("latch write changed counter");
	chk_count_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
		count_wr |=> count == $past(req.wdata) && latch == $past(req.wdata))
		else $error("counter write did not load both");
	chk_count_step: assert property (@(posedge clk_sys) disable iff (!rst_n) // R5
		pulse_edge && !count_wr && count != ALL_ONES
		|=> count == $past(count) + ONE)
		else $error("counter did not step by one");
	chk_count_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // R6
		req.rd && req.addr == OFF_COUNT |=> rdata == $past(count))
		else $error("counter read wrong");
	chk_reload_value: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
		s_wrap |=> count == $past(latch))
		else $error("overflow did not reload");
	chk_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
		s_wrap |=> counter_overflow_flag)
		else $error("overflow flag not set");
	chk_flag_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
		counter_overflow_flag && !flag_clr |=> counter_overflow_flag)
		else $error("overflow flag dropped");
	chk_full_modulus: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
		latch == ALL_ONES && count == ALL_ONES && pulse_edge && !count_wr
		|=> count == ALL_ONES && counter_overflow_flag)
		else $error("all-ones modulus not overflowing");
	chk_wrap_cond: assert property ( // R10
		@(posedge clk_sys) disable iff (!rst_n)
		pulse_edge && !count_wr && (count == ALL_ONES)
		|=> counter_overflow_flag && (count == $past(latch)))
		else $error("all-ones count did not wrap");

	chk_latch_keep: assert property ( // R2
		@(posedge clk_sys) disable iff (!rst_n)
		!count_wr && !latch_wr
		|=> $stable(latch))
		else $error("latch changed without a write");

	chk_count_keep: assert property ( // R7
		@(posedge clk_sys) disable iff (!rst_n)
		s_quiet
		|=> $stable(count))
		else $error("counter changed with no load or pulse");

	chk_read_pure: assert property ( // R6
		@(posedge clk_sys) disable iff (!rst_n)
		s_read(OFF_COUNT) ##0 s_quiet
		|=> $stable(count))
		else $error("counter read disturbed the count");

	chk_latch_read: assert property ( // R1
		@(posedge clk_sys) disable iff (!rst_n)
		s_read(OFF_LATCH)
		|=> rdata == $past(latch))
		else $error("latch read wrong");

	chk_status_read: assert property ( // R8
		@(posedge clk_sys) disable iff (!rst_n)
		s_read(OFF_STATUS)
		|=> rdata == ($past(counter_overflow_flag) ? ONE : ZERO))
		else $error("status read wrong");

	chk_enable_read: assert property ( // R8
		@(posedge clk_sys) disable iff (!rst_n)
		s_read(OFF_ENABLE)
		|=> rdata == ($past(irq_enable) ? ONE : ZERO))
		else $error("enable read wrong");

	chk_read_idle: assert property ( // R6
		@(posedge clk_sys) disable iff (!rst_n)
		!req.rd
		|=> rdata == ZERO)
		else $error("read data not zero outside a read");

	chk_edge_once: assert property ( // R5
		@(posedge clk_sys) disable iff (!rst_n)
		pulse_edge
		|=> !pulse_edge)
		else $error("one pin edge counted twice");

	chk_sync_path: assert property ( // R5
		@(posedge clk_sys) disable iff (!rst_n)
		s_arrive
		|-> pulse_edge)
		else $error("synchronised edge not detected");

	chk_write_wins: assert property ( // R3
		@(posedge clk_sys) disable iff (!rst_n)
		count_wr && pulse_edge && !counter_overflow_flag
		|=> !counter_overflow_flag)
		else $error("pulse beside a counter write wrapped");

	chk_set_wins: assert property ( // R11
		@(posedge clk_sys) disable iff (!rst_n)
		overflow && flag_clr
		|=> counter_overflow_flag)
		else $error("clear beat a same-cycle overflow");

	chk_flag_clear: assert property ( // R11
		@(posedge clk_sys) disable iff (!rst_n)
		flag_clr && !overflow
		|=> !counter_overflow_flag)
		else $error("flag clear ignored");

	chk_flag_source: assert property ( // R8
		@(posedge clk_sys) disable iff (!rst_n)
		!counter_overflow_flag && !overflow
		|=> !counter_overflow_flag)
		else $error("flag set without overflow");

	chk_irq_raise: assert property ( // R8
		@(posedge clk_sys) disable iff (!rst_n)
		s_wrap ##0 (irq_enable && !enable_wr)
		|=> irq)
		else $error("enabled overflow gave no interrupt");

	chk_enable_write: assert property ( // R8
		@(posedge clk_sys) disable iff (!rst_n)
		enable_wr
		|=> irq_enable == $past(req.wdata[FLAG_BIT]))
		else $error("enable write lost");

	chk_reset_state: assert property ( // R4
		@(posedge clk_sys)
		!rst_n
		|=> (count == COUNT_RST) && (rdata == ZERO)
		&& !counter_overflow_flag && !irq_enable && !irq)
		else $error("reset left state behind");

	chk_clear_read: assert property ( // R8
		@(posedge clk_sys) disable iff (!rst_n)
		s_read(OFF_CLEAR)
		|=> rdata == ZERO)
		else $error("clear register read not zero");

	chk_enable_keep: assert property ( // R8
		@(posedge clk_sys) disable iff (!rst_n)
		!enable_wr
		|=> $stable(irq_enable))
		else $error("enable changed without a write");

	chk_irq_drop: assert property ( // R11
		@(posedge clk_sys) disable iff (!rst_n)
		flag_clr && !overflow
		|=> !irq)
		else $error("interrupt held after clear");

	chk_step_flag: assert property ( // R10
		@(posedge clk_sys) disable iff (!rst_n)
		s_step ##0 !counter_overflow_flag
		|=> !counter_overflow_flag)
		else $error("plain step set the flag");

	chk_latch_kept: assert property ( // R7
		@(posedge clk_sys) disable iff (!rst_n)
		s_wrap ##0 !latch_wr
		|=> $stable(latch))
		else $error("reload disturbed the latch");

	chk_full_reload: assert property ( // R9
		@(posedge clk_sys) disable iff (!rst_n)
		s_wrap ##0 (latch == ALL_ONES)
		|=> count == ALL_ONES)
		else $error("full modulus reload not all ones");
endmodule // mcs_counter

// file: rtl/modulus_counter_submodule_pkg.sv
// package for the modulus counter submodule: register map and carriers
package mcs_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] OFF_LATCH = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_COUNT = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_CLEAR = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_ENABLE = 4'h4;
	localparam logic [DATA_W-1:0] LATCH_RST = 16'h0000;
	localparam logic [DATA_W-1:0] COUNT_RST = 16'h0000;
	localparam logic [DATA_W-1:0] ALL_ONES = 16'hffff;
	localparam logic [DATA_W-1:0] ONE = 16'h0001;
	localparam logic [DATA_W-1:0] ZERO = 16'h0000;
	localparam int FLAG_BIT = 0;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} mcs_req_type;
endpackage
